/* File: src/fosc_pkg.sv */
// Shared constants, register map and types for the float operand and sign control block
package fosc_pkg;

  // ***********************************
  // Register map (byte addresses)
  // ***********************************
  localparam int unsigned FOSC_ADDR_W = 8;
  localparam logic [7:0] FOSC_INSTR_OFS = 8'h00;
  localparam logic [7:0] FOSC_INDEX_OFS = 8'h04;
  localparam logic [7:0] FOSC_BASE_OFS = 8'h08;
  localparam logic [7:0] FOSC_MEMHI_OFS = 8'h0C;
  localparam logic [7:0] FOSC_MEMLO_OFS = 8'h10;
  localparam logic [7:0] FOSC_CTRL_OFS = 8'h14;
  localparam logic [7:0] FOSC_STATUS_OFS = 8'h18;
  localparam logic [7:0] FOSC_EADDR_OFS = 8'h1C;
  localparam logic [7:0] FOSC_LS_OFS = 8'h20;
  localparam logic [7:0] FOSC_LS_LAST_OFS = 8'h3C;

  // ***********************************
  // Control and status fields
  // ***********************************
  localparam int unsigned FOSC_CTRL_GO = 0;
  localparam int unsigned FOSC_CTRL_SIGMASK = 1;
  localparam int unsigned FOSC_ST_BUSY = 0;
  localparam int unsigned FOSC_ST_DONE = 1;
  localparam int unsigned FOSC_ST_CC = 2;
  localparam int unsigned FOSC_ST_SPEC = 4;
  localparam int unsigned FOSC_ST_OVF = 5;
  localparam int unsigned FOSC_ST_UNF = 6;
  localparam int unsigned FOSC_ST_SIGNIF = 7;
  localparam int unsigned FOSC_ST_SIGN1 = 8;
  localparam int unsigned FOSC_ST_SIGN2 = 9;
  localparam int unsigned FOSC_ST_CARRY = 10;
  localparam int unsigned FOSC_ST_PARTIAL = 11;

  // ***********************************
  // Datapath constants, condition codes and opcode decode values
  // ***********************************
  localparam logic [2:0] FOSC_STC_FP = 3'h4;
  localparam logic [2:0] FOSC_ABC_FP = 3'h0;
  localparam logic FOSC_LAL_FP = 1'h1;
  localparam logic [7:0] FOSC_BIAS = 8'h40;
  localparam logic [6:0] FOSC_CHAR_MAX = 7'h7F;
  localparam logic [1:0] FOSC_CC_ZERO = 2'h0;
  localparam logic [1:0] FOSC_CC_NEG = 2'h1;
  localparam logic [1:0] FOSC_CC_POS = 2'h2;
  localparam logic [7:0] FOSC_OP_SUBN_SHORT_MEM = 8'h78;
  localparam logic [3:0] FOSC_NIB_LPOS = 4'h0;
  localparam logic [3:0] FOSC_NIB_LNEG = 4'h1;
  localparam logic [3:0] FOSC_NIB_LTST = 4'h2;
  localparam logic [3:0] FOSC_NIB_LCMP = 4'h3;
  localparam logic [3:0] FOSC_NIB_LOAD = 4'h8;
  localparam logic [3:0] FOSC_NIB_SUBN = 4'hB;
  localparam logic [3:0] FOSC_NIB_MUL = 4'hC;
  localparam logic [3:0] FOSC_NIB_DIV = 4'hD;
  localparam logic [3:0] FOSC_NIB_SUBU = 4'hF;

  // ***********************************
  // Types
  // ***********************************
  typedef enum logic [2:0] {
    FOSC_C_NONE, FOSC_C_SUBN, FOSC_C_SUBU, FOSC_C_LPOS, FOSC_C_LNEG, FOSC_C_LTST,
    FOSC_C_LCMP, FOSC_C_MULDIV
  } fosc_cls_t;

  typedef enum logic [2:0] {
    FOSC_SA_PASS, FOSC_SA_ADD, FOSC_SA_INC, FOSC_SA_DEC, FOSC_SA_SUB64
  } fosc_sa_op_t;

  typedef enum logic [3:0] {
    FOSC_IDLE, FOSC_DECODE, FOSC_FETCH_AH, FOSC_FETCH_AL, FOSC_FETCH_BH, FOSC_FETCH_BL,
    FOSC_SIGNS, FOSC_BIAS_ST, FOSC_ALIGN, FOSC_ADD, FOSC_NORM, FOSC_STORE_H, FOSC_STORE_L
  } fosc_phase_t;

endpackage

/* File: src/fosc_serial_adder.sv */
// Serial byte adder for characteristics
module fosc_serial_adder (
  input wire fosc_pkg::fosc_sa_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  output logic [7:0] sum,
  output logic carry
);
  import fosc_pkg::*;

  logic [8:0] t;

  always_comb begin
    t = {1'b0, a};
    unique case (op)
      FOSC_SA_PASS: t = {1'b0, a};
      FOSC_SA_ADD: t = {1'b0, a} + {1'b0, b};
      FOSC_SA_INC: t = {1'b0, a} + 9'h001;
      FOSC_SA_DEC: t = {1'b0, a} - 9'h001;
      FOSC_SA_SUB64: t = {1'b0, a} - {1'b0, FOSC_BIAS};
    endcase
    sum = t[7:0];
    carry = t[8];
  end

endmodule // fosc_serial_adder

/* File: src/fosc_top.sv */
// Float operand addressing, specification check and sign control with APB registers
//
// Overview of operation
// [RULE1] Short normalized register subtract writes normalized difference, keeps both low halves.
// [RULE2] Unnormalized subtracts skip normalization and never flag exponent underflow.
// [RULE3] Short storage operand: address bit 21 picks right word if 1.
// [RULE4] Subtract sets condition code: 0 zero fraction, 1 negative, 2 positive.
// [RULE5] Long subtracts read each low fraction word from the odd word.
// [RULE6] Odd or above-seven register fields raise a specification error.
// [RULE7] Storage address must be word aligned short, doubleword aligned long.
// [RULE8] Effective address is displacement plus index and base; zero field adds nothing.
// [RULE9] Storage format: opcode, register, index, base, 12-bit displacement.
// [RULE10] Result overwrites the first operand only; nothing else is modified.
// [RULE11] Float registers 0,2,4,6 map to local store words 16..23 pairs.
// [RULE12] Local store address top bit forced to 1 for float operands.
// [RULE13] Low word access forces the lowest address bit to 1.
// [RULE14] Parallel adder adds fractions and shifts them by four bits.
// [RULE15] Characteristics go through serial adder; pointers 4 and 0; add1, sub1, sub64.
// [RULE16] Capture signs: second operand sign true or inverted, first operand sign alongside.
// [RULE17] Multiply or divide sets carry latch when characteristic sum carries.
// [RULE18] Minus result forces stored sign bit to 1, blocking normal sign.
// [RULE19] Result sign decoded from operation class and the sign latches.
// [RULE20] Both register fields may name the same float register.
//
// The placing of the registers and register access over APB were left to the implementer.
module fosc_top #(
  parameter int unsigned LS_WORDS = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [fosc_pkg::FOSC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import fosc_pkg::*;

  typedef struct packed {
    fosc_phase_t ph;
    logic [LS_WORDS-1:0][31:0] ls;
    logic [31:0] prdata;
    logic pslverr;
    logic [31:0] instr;
    logic [31:0] idx;
    logic [31:0] base;
    logic [31:0] mem_hi;
    logic [31:0] mem_lo;
    logic sigmask;
    logic busy;
    logic done;
    logic [1:0] cond_code;
    logic spec;
    logic ovf;
    logic unf;
    logic signif;
    logic partial;
    logic sign1;
    logic sign2;
    logic carry;
    logic [23:0] ea;
    logic [4:0] local_store_addr_reg;
    logic [2:0] st_byte_pointer;
    logic [2:0] ab_byte_pointer;
    logic [63:0] st_w;
    logic [63:0] ab_w;
    logic [55:0] fa;
    logic [55:0] fb;
    logic [6:0] ca;
    logic [6:0] cb;
    logic rsign;
  } fosc_state_t;

  fosc_state_t r;
  fosc_state_t n;

  // ***********************************
  // Decode helpers
  // ***********************************
  function automatic fosc_cls_t op_class(input logic [7:0] op);
    logic rx;
    rx = op[6];
    if (op == FOSC_OP_SUBN_SHORT_MEM) begin
      return FOSC_C_SUBN;
    end
    unique case (op[3:0])
      FOSC_NIB_SUBN: return FOSC_C_SUBN;
      FOSC_NIB_SUBU: return FOSC_C_SUBU;
      FOSC_NIB_MUL, FOSC_NIB_DIV: return FOSC_C_MULDIV;
      FOSC_NIB_LPOS: return rx ? FOSC_C_NONE : FOSC_C_LPOS;
      FOSC_NIB_LNEG: return rx ? FOSC_C_NONE : FOSC_C_LNEG;
      FOSC_NIB_LTST, FOSC_NIB_LOAD: return rx ? FOSC_C_NONE : FOSC_C_LTST;
      FOSC_NIB_LCMP: return rx ? FOSC_C_NONE : FOSC_C_LCMP;
      default: return FOSC_C_NONE;
    endcase
  endfunction

  function automatic logic is_sub(input fosc_cls_t c);
    return (c == FOSC_C_SUBN) || (c == FOSC_C_SUBU);
  endfunction

  // Result sign from class and latches
  function automatic logic result_minus(input fosc_cls_t c, input logic s1, input logic s2,
                                        input logic larger_neg);
    unique case (c)
      FOSC_C_MULDIV: return s1 != s2;
      FOSC_C_LCMP: return !s1;
      FOSC_C_LTST: return s1;
      FOSC_C_SUBN, FOSC_C_SUBU: return larger_neg;
      FOSC_C_LNEG: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] byte_of(input logic [63:0] w, input logic [2:0] p);
    return w[63 - 8 * p -: 8];
  endfunction

  // Four-bit fraction shift of the parallel adder
  function automatic logic [55:0] frac_shift(input logic [55:0] f, input logic left);
    return left ? {f[51:0], 4'h0} : {4'h0, f[55:4]};
  endfunction

  function automatic logic addr_ok(input logic [FOSC_ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a <= FOSC_LS_LAST_OFS);
  endfunction

  // ***********************************
  // Instruction fields and serial adder
  // ***********************************
  logic [7:0] opcode;
  logic [3:0] r1;
  logic [3:0] r2;
  logic [11:0] disp;
  logic rx_fmt;
  logic short_op;
  fosc_cls_t cls;
  fosc_sa_op_t sa_op;
  logic [7:0] sa_a;
  logic [7:0] sa_b;
  logic [7:0] sa_sum;
  logic [56:0] psum;
  logic frac_zero;
  logic [23:0] ea_calc;

  assign opcode = r.instr[31:24];
  assign r1 = r.instr[23:20];
  assign r2 = r.instr[19:16]; // [RULE9]
  assign disp = r.instr[11:0];
  assign rx_fmt = opcode[6];
  assign short_op = opcode[4];
  assign cls = op_class(opcode);
  assign frac_zero = (r.fa == 56'h0);
  assign ea_calc = 24'((r.instr[19:16] != 4'h0 ? r.idx : 32'h0) // [RULE8]
                   + (r.instr[15:12] != 4'h0 ? r.base : 32'h0) + {20'h0, disp});

  fosc_serial_adder u_serial_adder (
    .op(sa_op),
    .a(sa_a),
    .b(sa_b),
    .sum(sa_sum),
    .carry()
  );

  assign prdata = r.prdata;
  assign pslverr = r.pslverr;
  assign pready = 1'b1;

  // ***********************************
  // Next state
  // ***********************************
  always_comb begin
    n = r;
    sa_op = FOSC_SA_PASS;
    sa_a = 8'h00;
    sa_b = 8'h00;
    psum = 57'h0;
    // APB read data and error captured in the setup cycle
    if (psel && !penable) begin
      n.pslverr = !addr_ok(paddr);
      n.prdata = 32'h0;
      if (addr_ok(paddr) && paddr >= FOSC_LS_OFS) begin
        n.prdata = r.ls[paddr[4:2]];
      end else begin
        unique case (paddr)
          FOSC_INSTR_OFS: n.prdata = r.instr;
          FOSC_INDEX_OFS: n.prdata = r.idx;
          FOSC_BASE_OFS: n.prdata = r.base;
          FOSC_MEMHI_OFS: n.prdata = r.mem_hi;
          FOSC_MEMLO_OFS: n.prdata = r.mem_lo;
          FOSC_CTRL_OFS: n.prdata = {30'h0, r.sigmask, 1'b0};
          FOSC_STATUS_OFS: n.prdata = {20'h0, r.partial, r.carry, r.sign2, r.sign1, r.signif,
                                       r.unf, r.ovf, r.spec, r.cond_code, r.done, r.busy};
          FOSC_EADDR_OFS: n.prdata = {8'h0, r.ea};
          default: n.prdata = 32'h0;
        endcase
      end
    end
    // Writes take effect in the access cycle; operand words locked while busy
    if (psel && penable && pwrite && addr_ok(paddr) && !r.busy) begin
      if (paddr >= FOSC_LS_OFS) begin
        n.ls[paddr[4:2]] = pwdata;
      end else begin
        unique case (paddr)
          FOSC_INSTR_OFS: n.instr = pwdata;
          FOSC_INDEX_OFS: n.idx = pwdata;
          FOSC_BASE_OFS: n.base = pwdata;
          FOSC_MEMHI_OFS: n.mem_hi = pwdata;
          FOSC_MEMLO_OFS: n.mem_lo = pwdata;
          FOSC_CTRL_OFS: begin
            n.sigmask = pwdata[FOSC_CTRL_SIGMASK];
            if (pwdata[FOSC_CTRL_GO]) begin
              n.busy = 1'b1;
              n.done = 1'b0;
              n.spec = 1'b0;
              n.ovf = 1'b0;
              n.unf = 1'b0;
              n.signif = 1'b0;
              n.partial = 1'b0;
              n.carry = 1'b0;
              n.ph = FOSC_DECODE;
            end
          end
          default: n.ph = r.ph;
        endcase
      end
    end
    unique case (r.ph)
      FOSC_IDLE: n.local_store_addr_reg = r.local_store_addr_reg;
      FOSC_DECODE: begin
        n.ea = ea_calc;
        n.st_byte_pointer = FOSC_STC_FP; // [RULE15]
        n.ab_byte_pointer = FOSC_ABC_FP;
        n.local_store_addr_reg = {FOSC_LAL_FP, r1}; // [RULE12] [RULE11]
        n.ph = FOSC_FETCH_AH;
        if (r1[3] || r1[0] || (!rx_fmt && (r2[3] || r2[0])) // [RULE6]
            || (rx_fmt && (short_op ? ea_calc[1:0] != 2'h0 : ea_calc[2:0] != 3'h0))) begin
          n.spec = 1'b1; // [RULE7]
          n.busy = 1'b0;
          n.done = 1'b1;
          n.ph = FOSC_IDLE;
        end else if (cls == FOSC_C_NONE) begin
          n.partial = 1'b1;
          n.busy = 1'b0;
          n.done = 1'b1;
          n.ph = FOSC_IDLE;
        end
      end
      FOSC_FETCH_AH: begin
        n.ab_w = {r.ls[r.local_store_addr_reg[2:0]], 32'h0};
        if (!short_op) begin
          n.local_store_addr_reg = {FOSC_LAL_FP, r1[3:1], 1'b1}; // [RULE13]
          n.ph = FOSC_FETCH_AL;
        end else begin
          n.local_store_addr_reg = {FOSC_LAL_FP, r2};
          n.ph = FOSC_FETCH_BH;
        end
      end
      FOSC_FETCH_AL: begin
        n.ab_w[31:0] = r.ls[r.local_store_addr_reg[2:0]]; // [RULE5]
        n.local_store_addr_reg = {FOSC_LAL_FP, r2};
        n.ph = FOSC_FETCH_BH;
      end
      FOSC_FETCH_BH: begin
        n.ph = FOSC_SIGNS;
        if (rx_fmt) begin
          if (short_op) begin
            n.st_w = {32'h0, r.ea[2] ? r.mem_lo : r.mem_hi}; // [RULE3]
          end else begin
            n.st_w = {r.mem_lo, r.mem_hi};
          end
        end else begin
          n.st_w = {32'h0, r.ls[r.local_store_addr_reg[2:0]]}; // [RULE20]
          if (!short_op) begin
            n.local_store_addr_reg = {FOSC_LAL_FP, r2[3:1], 1'b1}; // [RULE13]
            n.ph = FOSC_FETCH_BL;
          end
        end
      end
      FOSC_FETCH_BL: begin
        n.st_w[63:32] = r.ls[r.local_store_addr_reg[2:0]]; // [RULE5]
        n.ph = FOSC_SIGNS;
      end
      FOSC_SIGNS: begin
        n.sign1 = byte_of(r.st_w, r.st_byte_pointer)[7] ^ is_sub(cls); // [RULE16]
        n.sign2 = byte_of(r.ab_w, r.ab_byte_pointer)[7];
        n.cb = byte_of(r.st_w, r.st_byte_pointer)[6:0];
        n.ca = byte_of(r.ab_w, r.ab_byte_pointer)[6:0];
        n.fb = {r.st_w[23:0], r.st_w[63:32]};
        n.fa = {r.ab_w[55:32], r.ab_w[31:0]};
        n.local_store_addr_reg = {FOSC_LAL_FP, r1};
        if (cls == FOSC_C_MULDIV) begin
          sa_op = FOSC_SA_ADD;
          sa_a = {1'b0, byte_of(r.ab_w, r.ab_byte_pointer)[6:0]};
          sa_b = {1'b0, byte_of(r.st_w, r.st_byte_pointer)[6:0]};
          n.ca = sa_sum[6:0];
          n.carry = sa_sum[7]; // [RULE17]
          n.ph = FOSC_BIAS_ST;
        end else if (is_sub(cls)) begin
          n.ph = FOSC_ALIGN;
        end else begin
          n.fa = {r.st_w[23:0], r.st_w[63:32]};
          n.ca = byte_of(r.st_w, r.st_byte_pointer)[6:0];
          n.rsign = result_minus(cls, n.sign1, n.sign2, 1'b0); // [RULE19]
          n.ph = FOSC_STORE_H;
        end
      end
      FOSC_BIAS_ST: begin
        sa_op = FOSC_SA_SUB64; // [RULE15]
        sa_a = {r.carry, r.ca};
        n.ca = sa_sum[6:0];
        n.partial = 1'b1;
        n.busy = 1'b0;
        n.done = 1'b1;
        n.ph = FOSC_IDLE;
      end
      FOSC_ALIGN: begin
        sa_op = FOSC_SA_INC; // [RULE15]
        if (r.ca == r.cb) begin
          n.ph = FOSC_ADD;
        end else if (r.ca < r.cb) begin
          sa_a = {1'b0, r.ca};
          n.ca = sa_sum[6:0];
          n.fa = frac_shift(r.fa, 1'b0); // [RULE14]
        end else begin
          sa_a = {1'b0, r.cb};
          n.cb = sa_sum[6:0];
          n.fb = frac_shift(r.fb, 1'b0); // [RULE14]
        end
      end
      FOSC_ADD: begin
        if (r.sign2 == r.sign1) begin
          psum = {1'b0, r.fa} + {1'b0, r.fb}; // [RULE14]
          n.rsign = result_minus(cls, r.sign1, r.sign2, r.sign2);
        end else if (r.fa >= r.fb) begin
          psum = {1'b0, r.fa} - {1'b0, r.fb};
          n.rsign = result_minus(cls, r.sign1, r.sign2, r.sign2); // [RULE19]
        end else begin
          psum = {1'b0, r.fb} - {1'b0, r.fa};
          n.rsign = result_minus(cls, r.sign1, r.sign2, r.sign1);
        end
        n.fa = psum[55:0];
        n.ph = FOSC_STORE_H;
        if (psum[56]) begin
          sa_op = FOSC_SA_INC;
          sa_a = {1'b0, r.ca};
          n.fa = {3'h0, psum[56:4]};
          n.ca = sa_sum[6:0];
          n.ovf = (r.ca == FOSC_CHAR_MAX);
        end else if (psum[55:0] == 56'h0) begin
          n.signif = 1'b1;
        end else if (cls == FOSC_C_SUBN) begin
          n.ph = FOSC_NORM; // [RULE1] [RULE2]
        end
      end
      FOSC_NORM: begin
        if (r.fa[55:52] == 4'h0) begin
          sa_op = FOSC_SA_DEC; // [RULE15]
          sa_a = {1'b0, r.ca};
          n.ca = sa_sum[6:0];
          n.fa = frac_shift(r.fa, 1'b1); // [RULE14]
          if (r.ca == 7'h00) begin
            n.unf = 1'b1;
          end
        end else begin
          n.ph = FOSC_STORE_H;
        end
      end
      FOSC_STORE_H: begin
        if (is_sub(cls) && frac_zero && !r.sigmask) begin
          n.ls[r.local_store_addr_reg[2:0]] = 32'h0;
        end else begin
          n.ls[r.local_store_addr_reg[2:0]] = {r.rsign, r.ca, r.fa[55:32]}; // [RULE18] [RULE10]
        end
        if (frac_zero) begin
          n.cond_code = FOSC_CC_ZERO; // [RULE4]
        end else begin
          n.cond_code = r.rsign ? FOSC_CC_NEG : FOSC_CC_POS;
        end
        if (!short_op) begin
          n.local_store_addr_reg = {FOSC_LAL_FP, r1[3:1], 1'b1}; // [RULE13]
          n.ph = FOSC_STORE_L;
        end else begin
          n.busy = 1'b0;
          n.done = 1'b1;
          n.ph = FOSC_IDLE;
        end
      end
      FOSC_STORE_L: begin
        n.ls[r.local_store_addr_reg[2:0]] = (is_sub(cls) && frac_zero && !r.sigmask) ?
                                            32'h0 : r.fa[31:0];
        n.busy = 1'b0;
        n.done = 1'b1;
        n.ph = FOSC_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  // ***********************************
  // Checks
  // ***********************************
  a_lal_top_forced: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
    (r.ph inside {FOSC_FETCH_AH, FOSC_FETCH_AL, FOSC_FETCH_BH, FOSC_STORE_H})
    |-> r.local_store_addr_reg[4]) else $error("float access without top address bit");
  a_low_word_odd: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
    (r.ph == FOSC_FETCH_AL || r.ph == FOSC_STORE_L) |-> r.local_store_addr_reg[0])
    else $error("low word access on even address");
  a_spec_odd_reg: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    (r.ph == FOSC_DECODE && (r1[0] || r1[3])) |=> (r.spec && r.done && !r.busy))
    else $error("odd register not refused");
  a_unnorm_no_unf: assert property (@(posedge pclk) disable iff (!presetn) // [RULE2]
    (cls == FOSC_C_SUBU && r.busy) |=> !$rose(r.unf)) else $error("underflow on unnormalized");
  a_cc_from_result: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
    (r.ph == FOSC_STORE_H && is_sub(cls) && !frac_zero)
    |=> r.cond_code == ($past(r.rsign) ? FOSC_CC_NEG : FOSC_CC_POS))
    else $error("condition code does not match result");
  a_short_keeps_low: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    (r.ph == FOSC_STORE_H && short_op) |=> $stable(r.ls[{r1[2:1], 1'b1}]))
    else $error("short store touched low half");
  a_byte_pointers: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
    (r.ph == FOSC_SIGNS) |-> (r.st_byte_pointer == FOSC_STC_FP && r.ab_byte_pointer == 3'h0))
    else $error("byte pointers not at float setting");
  a_force_minus: assert property (@(posedge pclk) disable iff (!presetn) // [RULE18]
    (r.ph == FOSC_STORE_H && r.rsign && !frac_zero) |=> r.ls[$past(r.local_store_addr_reg[2:0])][31])
    else $error("minus sign not forced");
  a_align_word: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
    (r.ph == FOSC_DECODE && rx_fmt && short_op && ea_calc[1:0] != 2'h0) |=> r.spec)
    else $error("misaligned short operand accepted");
  a_carry_latch: assert property (@(posedge pclk) disable iff (!presetn) // [RULE17]
    (r.ph == FOSC_SIGNS && cls == FOSC_C_MULDIV) |=> r.carry == $past(sa_sum[7]))
    else $error("carry latch mismatch");

endmodule // fosc_top

/* File: tb/fosc_apb_master.sv */
// APB master model driving the block's register port
module fosc_apb_master (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic stuck
);
  timeunit 1ns;
  timeprecision 1ps;
  import fosc_pkg::*;
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    stuck = 1'h0;
  end
  // *****************************
  // One transfer, setup then access
  // *****************************
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (pready !== 1'h1) stuck <= 1'h1;
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
endmodule // fosc_apb_master

/* File: tb/fosc_bench.sv */
// Self-checking bench for the float operand and sign control block
module fosc_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import fosc_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, stuck;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, st, q;
  int err_count, compares;
  logic [31:0] ctl = 32'h00000001;
  fosc_top #(.LS_WORDS(8)) i_fosc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  fosc_apb_master i_fosc_apb_master (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stuck(stuck));
  initial pclk = 1'h0;
  always #4 pclk = ~pclk;
  // *****************************
  // Shared tasks
  // *****************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge stuck) begin
    err_count++;
    close_out();
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    i_fosc_apb_master.xfer(1'h1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    i_fosc_apb_master.xfer(1'h0, a, 32'h00000000, r, e);
  endtask
  task automatic fp(input int n, input logic [31:0] hi, input logic [31:0] lo);
    wr(FOSC_LS_OFS + 8'(4 * n), hi);
    wr(FOSC_LS_OFS + 8'(4 * n + 4), lo);
  endtask
  task automatic chk_fp(input int n, input logic [31:0] hi, input logic [31:0] lo);
    rd(FOSC_LS_OFS + 8'(4 * n), q);
    check("float high", q, hi);
    rd(FOSC_LS_OFS + 8'(4 * n + 4), q);
    check("float low", q, lo);
  endtask
  // Start an operation and poll for completion; compare low status byte
  task automatic run(input logic [31:0] ins, input logic [31:0] exp_st);
    wr(FOSC_INSTR_OFS, ins);
    wr(FOSC_CTRL_OFS, ctl);
    for (int n = 0; n < 100; n++) begin
      rd(FOSC_STATUS_OFS, st);
      if (st[FOSC_ST_DONE] === 1'h1) break;
    end
    if (st[FOSC_ST_DONE] !== 1'h1) begin
      err_count++;
      close_out();
    end else begin
      check("status", st & 32'h000000FF, exp_st);
    end
  endtask
  // *****************************
  // Scenarios
  // *****************************
  task automatic t_reset();
    logic e;
    rd(FOSC_STATUS_OFS, q);
    check("status reset", q, 32'h00000000);
    rd(FOSC_LS_OFS, q);
    check("store reset", q, 32'h00000000);
    i_fosc_apb_master.xfer(1'h0, 8'h40, 32'h00000000, q, e);
    check("unmapped error", {31'h0, e}, 32'h00000001);
    check("unmapped data", q, 32'h00000000);
    $display("reset test done");
  endtask
  task automatic t_rr_short();
    fp(0, 32'h41200000, 32'h0000ABCD);
    fp(2, 32'h41100000, 32'h00001234);
    run(32'h3B020000, 32'h0000000A);
    chk_fp(0, 32'h41100000, 32'h0000ABCD);
    chk_fp(2, 32'h41100000, 32'h00001234);
    fp(0, 32'h41100000, 32'h0000ABCD);
    fp(2, 32'h41200000, 32'h00001234);
    run(32'h3B020000, 32'h00000006);
    chk_fp(0, 32'hC1100000, 32'h0000ABCD);
    fp(0, 32'h41100000, 32'h0000ABCD);
    run(32'h3B000000, 32'h00000082);
    chk_fp(0, 32'h00000000, 32'h0000ABCD);
    $display("short register test done");
  endtask
  task automatic t_spec();
    logic [31:0] bad[4] = '{32'h3B100000, 32'h3B800000, 32'h3B010000, 32'h3B080000};
    fp(0, 32'h41200000, 32'h00000005);
    foreach (bad[i]) begin
      run(bad[i], 32'h00000012);
      chk_fp(0, 32'h41200000, 32'h00000005);
    end
    $display("register field test done");
  endtask
  task automatic t_rx();
    wr(FOSC_INDEX_OFS, 32'h00000010);
    wr(FOSC_BASE_OFS, 32'h00000020);
    wr(FOSC_MEMHI_OFS, 32'h41300000);
    wr(FOSC_MEMLO_OFS, 32'h40800000);
    fp(4, 32'h41100000, 32'h0000BEEF);
    run(32'h7F412004, 32'h0000000A);
    rd(FOSC_EADDR_OFS, q);
    check("effective address", q, 32'h00000034);
    chk_fp(4, 32'h41080000, 32'h0000BEEF);
    run(32'h7F402000, 32'h00000006);
    rd(FOSC_EADDR_OFS, q);
    check("effective address", q, 32'h00000020);
    chk_fp(4, 32'hC1280000, 32'h0000BEEF);
    run(32'h7F402002, 32'h00000016);
    run(32'h6F402004, 32'h00000016);
    chk_fp(4, 32'hC1280000, 32'h0000BEEF);
    $display("storage form test done");
  endtask
  task automatic t_long();
    fp(0, 32'h41200000, 32'h00000003);
    fp(2, 32'h41100000, 32'h00000001);
    run(32'h2F020000, 32'h0000000A);
    chk_fp(0, 32'h41100000, 32'h00000002);
    $display("long register test done");
  endtask
  task automatic t_misc();
    wr(FOSC_MEMHI_OFS, 32'h41100000);
    fp(6, 32'h41180000, 32'h00000077);
    run(32'h78600008, 32'h0000000A);
    chk_fp(6, 32'h40800000, 32'h00000077);
    rd(FOSC_STATUS_OFS, q);
    check("sign latches", q & 32'h00000300, 32'h00000100);
    ctl = 32'h00000003;
    run(32'h3B660000, 32'h00000082);
    chk_fp(6, 32'h40000000, 32'h00000077);
    ctl = 32'h00000001;
    fp(0, 32'h41200000, 32'h00000000);
    fp(2, 32'hC1100000, 32'h00000000);
    run(32'h3C020000, 32'h00000002);
    rd(FOSC_STATUS_OFS, q);
    check("mul status", q & 32'h00000F00, 32'h00000D00);
    chk_fp(0, 32'h41200000, 32'h00000000);
    run(32'h33020000, 32'h0000000A);
    chk_fp(0, 32'h41100000, 32'h00000000);
    $display("misc test done");
  endtask
  initial begin
    presetn = 1'h0;
    err_count = 0;
    compares = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_rr_short();
    t_spec();
    t_rx();
    t_long();
    t_misc();
    close_out();
  end
endmodule // fosc_bench
